// ### spr_pkg.sv
package spr_pkg;

  // ----------------------------------------------------------------
  // Register map and bus widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_GAIN = 4'h1;
  localparam logic [3:0] REG_SPAN = 4'h2;
  localparam logic [3:0] REG_SETPOINT = 4'h3;
  localparam logic [3:0] REG_LO_CLAMP = 4'h4;
  localparam logic [3:0] REG_HI_CLAMP = 4'h5;
  localparam logic [3:0] REG_SCALE = 4'h6;
  localparam logic [3:0] REG_BIAS = 4'h7;
  localparam logic [3:0] REG_MANUAL = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'h9;
  localparam logic [3:0] REG_OUTPUT = 4'ha;
  localparam logic [3:0] REG_INTEG = 4'hb;

  // ----------------------------------------------------------------
  // Value ranges (gain and scale in hundredths, span in seconds)
  // ----------------------------------------------------------------
  localparam int OUT_MAX = 1000;
  localparam int GAIN_MAX = 9999;
  localparam int SPAN_MIN = 1;
  localparam int SPAN_MAX = 5999;
  localparam int PAR_MIN = -10000;
  localparam int PAR_MAX = 20000;
  localparam int SCALE_LIM = 1000;
  localparam int BIAS_LIM = 10000;
  localparam int FRAC = 100;
  localparam int GAIN_DIV = FRAC * FRAC;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [13:0] RST_GAIN = 14'h0064;
  localparam logic [12:0] RST_SPAN = 13'h003c;
  localparam logic [15:0] RST_LO = 16'hd8f0;
  localparam logic [15:0] RST_HI = 16'h4e20;
  localparam logic [15:0] RST_SCALE = 16'h0064;

  // ----------------------------------------------------------------
  // Sample timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int SAMPLE_MS = 500;
  localparam int SAMPLE_CYC = SAMPLE_MS * (CLK_HZ / 1000);
  localparam int ISPAN_DIV = GAIN_DIV * 1000 / SAMPLE_MS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] preset;
    logic use_preset;
    logic sense_neg;
  } spr_ctrl_t;

  typedef struct packed {
    logic [13:0] gain;
    logic [12:0] span;
    logic sense_neg;
  } spr_preset_t;

  localparam int NUM_PRESETS = 6;
  localparam spr_preset_t PRESETS [0:NUM_PRESETS-1] = '{
    '{gain: 14'h0032, span: 13'h001e, sense_neg: 1'b0},
    '{gain: 14'h0064, span: 13'h0078, sense_neg: 1'b0},
    '{gain: 14'h012c, span: 13'h0005, sense_neg: 1'b0},
    '{gain: 14'h0078, span: 13'h000c, sense_neg: 1'b0},
    '{gain: 14'h0064, span: 13'h0001, sense_neg: 1'b0},
    '{gain: 14'h0046, span: 13'h0014, sense_neg: 1'b0}
  };

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIVP = 2'b01,
    ST_DIVI = 2'b11,
    ST_APPLY = 2'b10
  } spr_state_t;

endpackage : spr_pkg

// ### spr_udiv.sv
`timescale 1ns/1ps
module spr_udiv #(
  parameter int W = 40
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst, // Async reset
  input wire logic i_start, // Load operands, one pulse
  input wire logic [W-1:0] i_dividend, // Unsigned dividend
  input wire logic [W-1:0] i_divisor, // Unsigned divisor, nonzero
  output logic o_done, // Quotient valid pulse
  output logic [W-1:0] o_quot // Quotient
);

  localparam int CW = $clog2(W + 1);

  logic [W:0] rem;
  logic [W-1:0] dvs;
  logic [CW-1:0] cnt;
  logic busy;
  logic [W:0] shifted;

  // One quotient bit per cycle; small area traded for W cycles
  assign shifted = {rem[W-1:0], o_quot[W-1]};

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rem <= '0;
      dvs <= '0;
      o_quot <= '0;
      cnt <= '0;
      busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        rem <= '0;
        dvs <= i_divisor;
        o_quot <= i_dividend;
        cnt <= CW'(W);
        busy <= 1'b1;
      end else if (busy) begin
        if (shifted >= {1'b0, dvs}) begin
          rem <= shifted - {1'b0, dvs};
          o_quot <= {o_quot[W-2:0], 1'b1};
        end else begin
          rem <= shifted;
          o_quot <= {o_quot[W-2:0], 1'b0};
        end
        cnt <= cnt - 1'b1;
        if (cnt == CW'(1)) begin
          busy <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end

endmodule : spr_udiv

// ### spr_regulator.sv
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Function
// - Mode input 1 selects automatic mode, 0 selects manual mode.
// - Clear input holds output at zero and overrides mode input.
// - Manual mode drives output with the manual output value.
// - Manual output value accepts zero to one thousand.
// - Control output always stays within zero to one thousand.
// - Entering automatic mode loads accumulator with manual output value.
// - Corrected value is raw value times scale plus bias.
// - Raw value beyond a clamp makes corrected value equal that clamp.
// - Corrected value equal to setpoint leaves output unchanged.
// - Positive sense: above setpoint lowers output, below raises it.
// - Negative sense: above setpoint raises output, below lowers it.
// - Regulation result recomputed once every 500 ms.
// - Loop gain accepts 00.00 to 99.99.
// - Integral span accepts 00:01 to 99:59 minutes.
// - Clamps and setpoint accept -10000 to +20000.
// - Scale within plus or minus 10.00, bias within 10000.
// - Selectable presets of gain, integral span and sense.
// - Error is setpoint minus corrected value each sample.
// - Output is P term plus integral step plus previous accumulator.
module spr_regulator #(
  parameter int SAMPLE_CYC = spr_pkg::SAMPLE_CYC
) (
  input wire logic i_clk_sys, // 20 MHz system clock
  input wire logic i_rst, // Async reset, active high
  input wire logic [3:0] i_addr, // Register address
  input wire logic [31:0] i_wdata, // Register write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [31:0] o_rdata, // Read data, cycle after i_rd
  input wire logic i_auto, // Mode select, 1 = automatic
  input wire logic i_clear, // Clear, forces output to zero
  input wire logic [15:0] i_process_value, // Raw process value, signed
  output logic [9:0] o_control_output // Manipulated variable
);

  localparam int W = 40;
  localparam int CW = $clog2(SAMPLE_CYC);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic signed [W-1:0] spr_sat(input logic signed [W-1:0] v,
                                                  input int lo, input int hi);
    logic signed [W-1:0] r;
    r = v;
    if (v < W'(lo)) begin
      r = W'(lo);
    end else if (v > W'(hi)) begin
      r = W'(hi);
    end
    return r;
  endfunction : spr_sat

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  spr_pkg::spr_ctrl_t ctrl;
  logic [13:0] loop_gain;
  logic [12:0] integral_span;
  logic signed [15:0] setpoint;
  logic signed [15:0] lo_clamp;
  logic signed [15:0] hi_clamp;
  logic signed [15:0] scale;
  logic signed [15:0] bias;
  logic [9:0] manual_output_value;
  logic signed [W-1:0] wval;

  assign wval = W'(signed'(i_wdata));

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl <= '0;
      loop_gain <= spr_pkg::RST_GAIN;
      integral_span <= spr_pkg::RST_SPAN;
      setpoint <= '0;
      lo_clamp <= spr_pkg::RST_LO;
      hi_clamp <= spr_pkg::RST_HI;
      scale <= spr_pkg::RST_SCALE;
      bias <= '0;
      manual_output_value <= '0;
    end else if (i_wr) begin
      if (i_addr == spr_pkg::REG_CTRL) begin
        ctrl <= spr_pkg::spr_ctrl_t'(i_wdata[$bits(spr_pkg::spr_ctrl_t)-1:0]);
      end else if (i_addr == spr_pkg::REG_GAIN) begin
        loop_gain <= 14'(spr_sat(wval, 0, spr_pkg::GAIN_MAX));
      end else if (i_addr == spr_pkg::REG_SPAN) begin
        integral_span <= 13'(spr_sat(wval, spr_pkg::SPAN_MIN, spr_pkg::SPAN_MAX));
      end else if (i_addr == spr_pkg::REG_SETPOINT) begin
        setpoint <= 16'(spr_sat(wval, spr_pkg::PAR_MIN, spr_pkg::PAR_MAX));
      end else if (i_addr == spr_pkg::REG_LO_CLAMP) begin
        lo_clamp <= 16'(spr_sat(wval, spr_pkg::PAR_MIN, spr_pkg::PAR_MAX));
      end else if (i_addr == spr_pkg::REG_HI_CLAMP) begin
        hi_clamp <= 16'(spr_sat(wval, spr_pkg::PAR_MIN, spr_pkg::PAR_MAX));
      end else if (i_addr == spr_pkg::REG_SCALE) begin
        scale <= 16'(spr_sat(wval, -spr_pkg::SCALE_LIM, spr_pkg::SCALE_LIM));
      end else if (i_addr == spr_pkg::REG_BIAS) begin
        bias <= 16'(spr_sat(wval, -spr_pkg::BIAS_LIM, spr_pkg::BIAS_LIM));
      end else if (i_addr == spr_pkg::REG_MANUAL) begin
        manual_output_value <= 10'(spr_sat(wval, 0, spr_pkg::OUT_MAX));
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode tracking
  // ----------------------------------------------------------------
  logic run;
  logic run_q;
  logic entry;
  logic sense_run;

  assign run = !i_clear && i_auto;
  assign entry = run && !run_q;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run;
    end
  end

  spr_pkg::spr_preset_t preset;
  logic [13:0] gain_eff;
  logic [12:0] span_eff;

  always_comb begin
    preset = spr_pkg::PRESETS[0];
    if (int'(ctrl.preset) < spr_pkg::NUM_PRESETS) begin
      preset = spr_pkg::PRESETS[ctrl.preset];
    end
  end

  assign gain_eff = ctrl.use_preset ? preset.gain : loop_gain;
  assign span_eff = ctrl.use_preset ? preset.span : integral_span;

  // Sense is captured on entry so a later write cannot flip a running loop
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sense_run <= 1'b0;
    end else if (entry) begin
      sense_run <= ctrl.use_preset ? preset.sense_neg : ctrl.sense_neg;
    end
  end

  // ----------------------------------------------------------------
  // Sample tick
  // ----------------------------------------------------------------
  logic [CW-1:0] tick_cnt;
  logic tick;

  assign tick = (tick_cnt == CW'(SAMPLE_CYC - 1));

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Corrected value and error, both held in hundredths
  // ----------------------------------------------------------------
  logic signed [15:0] raw;
  logic signed [W-1:0] corr100;
  logic signed [W-1:0] err100;
  logic signed [W-1:0] err_eff;
  logic [W-1:0] err_mag;
  logic [W-1:0] prod_mag;

  assign raw = signed'(i_process_value);

  always_comb begin
    if (raw > hi_clamp) begin
      corr100 = W'(hi_clamp) * W'(spr_pkg::FRAC);
    end else if (raw < lo_clamp) begin
      corr100 = W'(lo_clamp) * W'(spr_pkg::FRAC);
    end else begin
      corr100 = W'(raw) * W'(scale) + W'(bias) * W'(spr_pkg::FRAC);
    end
  end

  assign err100 = W'(setpoint) * W'(spr_pkg::FRAC) - corr100;
  assign err_eff = sense_run ? -err100 : err100;
  assign err_mag = err_eff[W-1] ? W'(-err_eff) : W'(err_eff);
  assign prod_mag = err_mag * W'(gain_eff);

  // ----------------------------------------------------------------
  // Sample sequencer
  // ----------------------------------------------------------------
  spr_pkg::spr_state_t state;
  logic neg;
  logic [W-1:0] prod_q;
  logic [W-1:0] p_mag;
  logic [W-1:0] i_mag;
  logic go;
  logic div_start;
  logic div_done;
  logic [W-1:0] div_quot;
  logic [W-1:0] div_dividend;
  logic [W-1:0] div_divisor;

  // Zero error skips the sample entirely, keeping the output as it is
  assign go = tick && run && !entry && (err100 != '0);
  assign div_start = (state == spr_pkg::ST_IDLE && go) ||
                     (state == spr_pkg::ST_DIVP && div_done);
  assign div_dividend = (state == spr_pkg::ST_IDLE) ? prod_mag : prod_q;
  assign div_divisor = (state == spr_pkg::ST_IDLE) ? W'(spr_pkg::GAIN_DIV) :
                       W'(span_eff) * W'(spr_pkg::ISPAN_DIV);

  spr_udiv #(.W(W)) u_div (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_start(div_start),
    .i_dividend(div_dividend),
    .i_divisor(div_divisor),
    .o_done(div_done),
    .o_quot(div_quot)
  );

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state <= spr_pkg::ST_IDLE;
      neg <= 1'b0;
      prod_q <= '0;
      p_mag <= '0;
      i_mag <= '0;
    end else if (!run) begin
      state <= spr_pkg::ST_IDLE;
    end else begin
      case (state)
        spr_pkg::ST_IDLE: begin
          if (go) begin
            neg <= err_eff[W-1];
            prod_q <= prod_mag;
            state <= spr_pkg::ST_DIVP;
          end
        end
        spr_pkg::ST_DIVP: begin
          if (div_done) begin
            p_mag <= div_quot;
            state <= spr_pkg::ST_DIVI;
          end
        end
        spr_pkg::ST_DIVI: begin
          if (div_done) begin
            i_mag <= div_quot;
            state <= spr_pkg::ST_APPLY;
          end
        end
        default: begin
          state <= spr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and output
  // ----------------------------------------------------------------
  logic [9:0] integ;
  logic signed [W-1:0] next_integ;
  logic signed [W-1:0] next_out;

  always_comb begin
    next_integ = W'(integ) + (neg ? -signed'(i_mag) : signed'(i_mag));
    next_integ = spr_sat(next_integ, 0, spr_pkg::OUT_MAX);
    next_out = next_integ + (neg ? -signed'(p_mag) : signed'(p_mag));
    next_out = spr_sat(next_out, 0, spr_pkg::OUT_MAX);
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      integ <= '0;
    end else if (entry) begin
      integ <= manual_output_value;
    end else if (run && state == spr_pkg::ST_APPLY) begin
      integ <= 10'(next_integ);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_control_output <= '0;
    end else if (i_clear) begin
      o_control_output <= '0;
    end else if (!i_auto) begin
      o_control_output <= manual_output_value;
    end else if (state == spr_pkg::ST_APPLY) begin
      o_control_output <= 10'(next_out);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      if (i_addr == spr_pkg::REG_CTRL) begin
        o_rdata <= 32'(ctrl);
      end else if (i_addr == spr_pkg::REG_GAIN) begin
        o_rdata <= 32'(loop_gain);
      end else if (i_addr == spr_pkg::REG_SPAN) begin
        o_rdata <= 32'(integral_span);
      end else if (i_addr == spr_pkg::REG_SETPOINT) begin
        o_rdata <= 32'(setpoint);
      end else if (i_addr == spr_pkg::REG_LO_CLAMP) begin
        o_rdata <= 32'(lo_clamp);
      end else if (i_addr == spr_pkg::REG_HI_CLAMP) begin
        o_rdata <= 32'(hi_clamp);
      end else if (i_addr == spr_pkg::REG_SCALE) begin
        o_rdata <= 32'(scale);
      end else if (i_addr == spr_pkg::REG_BIAS) begin
        o_rdata <= 32'(bias);
      end else if (i_addr == spr_pkg::REG_MANUAL) begin
        o_rdata <= 32'(manual_output_value);
      end else if (i_addr == spr_pkg::REG_STATUS) begin
        o_rdata <= 32'({sense_run, i_clear, run});
      end else if (i_addr == spr_pkg::REG_OUTPUT) begin
        o_rdata <= 32'(o_control_output);
      end else if (i_addr == spr_pkg::REG_INTEG) begin
        o_rdata <= 32'(integ);
      end else begin
        o_rdata <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  logic [31:0] gap;
  logic seen_tick;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      gap <= '0;
      seen_tick <= 1'b0;
    end else if (tick) begin
      gap <= '0;
      seen_tick <= 1'b1;
    end else begin
      gap <= gap + 1'b1;
    end
  end

  sequence s_enter_auto;
    run && !run_q;
  endsequence

  sequence s_apply_lower;
    state == spr_pkg::ST_APPLY && run && neg;
  endsequence

  clear_zero_a: assert property (i_clear |=> o_control_output == '0)
    else $error("output not zero after clear");
  manual_drive_a: assert property ((!i_clear && !i_auto) |=>
    o_control_output == $past(manual_output_value))
    else $error("manual value not driven");
  out_range_a: assert property (int'(o_control_output) <= spr_pkg::OUT_MAX)
    else $error("output out of range");
  auto_init_a: assert property (s_enter_auto |=>
    integ == $past(manual_output_value) && state == spr_pkg::ST_IDLE)
    else $error("accumulator not loaded on entry");
  sample_period_a: assert property ((tick && seen_tick) |->
    gap == 32'(SAMPLE_CYC - 1))
    else $error("sample period wrong");
  equal_hold_a: assert property ((run && !entry && err100 == '0 &&
    state == spr_pkg::ST_IDLE) |=> $stable(o_control_output))
    else $error("output moved at zero error");
  sense_lower_a: assert property (s_apply_lower |=>
    integ <= $past(integ) && o_control_output <= $past(integ))
    else $error("lowering step raised output");
  sense_latch_a: assert property ((run_q && run) |=> $stable(sense_run))
    else $error("sense changed while running");
  clamp_high_a: assert property ((raw > hi_clamp && run) |->
    err100 == W'(setpoint) * W'(spr_pkg::FRAC) - W'(hi_clamp) * W'(spr_pkg::FRAC))
    else $error("upper clamp not applied");
  gain_range_a: assert property (i_wr && i_addr == spr_pkg::REG_GAIN |=>
    int'(loop_gain) <= spr_pkg::GAIN_MAX)
    else $error("gain out of range");

endmodule : spr_regulator

// ### spr_ctl_prog.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Control program stand-in
// ----------------------------------------------------------------
// Outputs move once per scan, just after an edge, like a program cycle
module spr_ctl_prog (
  input wire logic i_clk_sys, // System clock
  input wire logic i_auto_req, // Mode wanted by the program
  input wire logic i_clear_req, // Clear wanted by the program
  input wire logic [15:0] i_pv_req, // Raw process value wanted
  output logic o_auto = 1'b0, // Mode select to regulator
  output logic o_clear = 1'b0, // Clear to regulator
  output logic [15:0] o_process_value = 16'h0000 // Raw process value to regulator
);
  always @(posedge i_clk_sys) begin
    o_auto <= i_auto_req;
    o_clear <= i_clear_req;
    o_process_value <= i_pv_req;
  end
endmodule : spr_ctl_prog

// ### spr_regulator_test.sv
`timescale 1ns/1ps
module spr_regulator_test;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic auto_req = 1'b0;
  logic clear_req = 1'b0;
  logic [15:0] pv_req = 16'h0000;
  logic i_auto;
  logic i_clear;
  logic [15:0] i_process_value;
  logic [9:0] o_control_output;
  int n_mismatch = 0;
  int n_tests = 0;
  localparam logic [2:0] PSET [0:3] = '{3'h0, 3'h1, 3'h3, 3'h5};
  localparam logic [9:0] PSET_OUT [0:3] = '{10'h1f9, 10'h1fe, 10'h200, 10'h1fb};

  always #25 i_clk_sys = ~i_clk_sys;

  // Short sample period keeps the run small
  spr_regulator #(.SAMPLE_CYC(200)) dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_auto(i_auto), .i_clear(i_clear),
    .i_process_value(i_process_value), .o_control_output(o_control_output)
  );
  spr_ctl_prog prog (
    .i_clk_sys(i_clk_sys), .i_auto_req(auto_req), .i_clear_req(clear_req),
    .i_pv_req(pv_req), .o_auto(i_auto), .o_clear(i_clear), .o_process_value(i_process_value)
  );

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic out_chk(input string name, input logic [9:0] exp);
    chk(name, {22'h0, exp}, {22'h0, o_control_output});
  endtask : out_chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    chk(name, exp, o_rdata);
  endtask : rd_chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : wait_cyc

  // Sense is only touched while in manual, never while regulating
  task automatic enter_auto(input logic [31:0] ctrl, input logic [15:0] pv);
    @(posedge i_clk_sys);
    auto_req <= 1'b0;
    wait_cyc(3);
    wr(spr_pkg::REG_CTRL, ctrl);
    pv_req <= pv;
    auto_req <= 1'b1;
    // Long enough for a skipped entry tick plus one full computation
    wait_cyc(330);
  endtask : enter_auto

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    n_mismatch++;
    $display("Error watchdog expired");
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd_chk("gain", spr_pkg::REG_GAIN, 32'h64);
    rd_chk("span", spr_pkg::REG_SPAN, 32'h3c);
    rd_chk("lo", spr_pkg::REG_LO_CLAMP, 32'hffffd8f0);
    rd_chk("hi", spr_pkg::REG_HI_CLAMP, 32'h4e20);
    rd_chk("scale", spr_pkg::REG_SCALE, 32'h64);
    rd_chk("unmapped", 4'hc, 32'h0);
    wr(spr_pkg::REG_MANUAL, 32'h7d0);
    rd_chk("manual", spr_pkg::REG_MANUAL, 32'h3e8);
    wr(spr_pkg::REG_GAIN, 32'h4e20);
    rd_chk("gain", spr_pkg::REG_GAIN, 32'h270f);
    wr(spr_pkg::REG_SPAN, 32'h0);
    rd_chk("span", spr_pkg::REG_SPAN, 32'h1);
    wr(spr_pkg::REG_SETPOINT, 32'h7530);
    rd_chk("setpoint", spr_pkg::REG_SETPOINT, 32'h4e20);
    wr(spr_pkg::REG_SCALE, 32'hffffec78);
    rd_chk("scale", spr_pkg::REG_SCALE, 32'hfffffc18);
    wr(spr_pkg::REG_BIAS, 32'h4e20);
    rd_chk("bias", spr_pkg::REG_BIAS, 32'h2710);
    wr(spr_pkg::REG_GAIN, 32'h64);
    wr(spr_pkg::REG_SPAN, 32'h3c);
    wr(spr_pkg::REG_SETPOINT, 32'h64);
    wr(spr_pkg::REG_SCALE, 32'h64);
    wr(spr_pkg::REG_BIAS, 32'h0);
    wr(spr_pkg::REG_MANUAL, 32'h1f4);
    // Clear wins over a live error in automatic mode
    clear_req <= 1'b1;
    auto_req <= 1'b1;
    pv_req <= 16'h005a;
    wait_cyc(330);
    out_chk("clear out", 10'h0);
    clear_req <= 1'b0;
    auto_req <= 1'b0;
    wait_cyc(4);
    out_chk("manual out", 10'h1f4);
    enter_auto(32'h0, 16'h0064);
    out_chk("zero error", 10'h1f4);
    rd_chk("integ", spr_pkg::REG_INTEG, 32'h1f4);
    rd_chk("status", spr_pkg::REG_STATUS, 32'h1);
    enter_auto(32'h0, 16'h005a);
    out_chk("pos below", 10'h1fe);
    enter_auto(32'h1, 16'h005a);
    out_chk("neg below", 10'h1ea);
    wr(spr_pkg::REG_LO_CLAMP, 32'h32);
    wr(spr_pkg::REG_HI_CLAMP, 32'h96);
    enter_auto(32'h0, 16'h012c);
    out_chk("hi clamp", 10'h1c2);
    enter_auto(32'h0, 16'hfffb);
    out_chk("lo clamp", 10'h226);
    wr(spr_pkg::REG_SCALE, 32'hc8);
    wr(spr_pkg::REG_BIAS, 32'ha);
    enter_auto(32'h0, 16'h003c);
    out_chk("scaled", 10'h1d6);
    wr(spr_pkg::REG_SCALE, 32'h64);
    wr(spr_pkg::REG_BIAS, 32'h0);
    wr(spr_pkg::REG_GAIN, 32'h270f);
    enter_auto(32'h0, 16'hfffb);
    out_chk("sat high", 10'h3e8);
    enter_auto(32'h0, 16'h012c);
    out_chk("sat low", 10'h0);
    wr(spr_pkg::REG_GAIN, 32'h64);
    enter_auto(32'h0, 16'h005a);
    clear_req <= 1'b1;
    wr(spr_pkg::REG_MANUAL, 32'h258);
    wait_cyc(4);
    out_chk("clear run", 10'h0);
    clear_req <= 1'b0;
    wait_cyc(330);
    out_chk("resume", 10'h262);
    wr(spr_pkg::REG_MANUAL, 32'h1f4);
    for (int i = 0; i < 4; i++) begin
      enter_auto({27'h0, PSET[i], 2'b10}, 16'h005a);
      out_chk("preset", PSET_OUT[i]);
    end
    rd_chk("output reg", spr_pkg::REG_OUTPUT, 32'h1fb);
    rd_chk("ctrl", spr_pkg::REG_CTRL, 32'h16);
    // Index past the table falls back to the first preset
    enter_auto(32'h1a, 16'h005a);
    out_chk("preset wrap", 10'h1f9);
    finish_test();
  end
endmodule : spr_regulator_test
